// ===== core/pss_pkg.sv
package pss_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACT_MIN_CYC = 8;
  localparam int MRD_MIN_CYC = 8;
  localparam int INDIS_CYC = 1;
  localparam int CKOFF_MIN_CYC = 5;
  localparam int CKEV_MIN_CYC = 2;
  localparam int FIXOUT_CYC = 2;
  localparam int CNT_W = 4;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  typedef enum logic [2:0] {
    PSS_RESET, PSS_ACTIVE, PSS_ENTER, PSS_SAVE, PSS_EXIT
  } pss_state_t;
endpackage : pss_pkg

// ===== core/pss_sync.sv
`timescale 1ns/1ps
module pss_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  always_comb begin
    next_meta = d;
    next_q = meta;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule : pss_sync

// ===== core/pss_seq.sv
`timescale 1ns/1ps
module pss_seq
  import pss_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [1:0] clock_enable_inputs,
  input wire logic control_field_upper_bit,
  input wire logic control_field_lower_bit,
  input wire logic clock_stopped,
  output logic input_buffers_enable,
  output logic cke_buffers_enable,
  output logic [1:0] registered_clock_enable_outputs,
  output logic redriven_oe,
  output logic static_outputs_valid,
  output logic power_save_active
);
  // pin-side copies after two flops each
  logic [1:0] cke_s;
  logic [1:0] ps_s;
  logic stop_s;

  // sequencer state
  pss_state_t state;
  pss_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] stop_cnt;
  logic [CNT_W-1:0] next_stop_cnt;

  // buffer controls
  logic next_inbuf;
  logic next_ckebuf;
  logic next_static;
  logic next_psa;
  logic [1:0] next_qcke;

  // output enable path
  logic half_oe;
  logic next_half_oe;
  logic oe_neg;
  logic next_oe_neg;

  // decoded conditions
  logic ps_on;
  logic cke_all_low;
  logic boot;
  logic enter_save;
  logic leave_save;
  logic stop_expired;

  pss_sync #(
    .W(2)
  ) u_cke (
    .core_clk(core_clk),
    .rstn(rstn),
    .d(clock_enable_inputs),
    .q(cke_s)
  );

  pss_sync #(
    .W(2)
  ) u_ps (
    .core_clk(core_clk),
    .rstn(rstn),
    .d({control_field_upper_bit, control_field_lower_bit}),
    .q(ps_s)
  );

  pss_sync #(
    .W(1)
  ) u_stop (
    .core_clk(core_clk),
    .rstn(rstn),
    .d(clock_stopped),
    .q(stop_s)
  );

  // lower bit is a don't-care, only the upper bit arms power save
  assign ps_on = ps_s[1];
  assign cke_all_low = (cke_s == 2'h0);
  assign boot = (state == PSS_RESET);
  assign enter_save = (state == PSS_ENTER) && cke_all_low && (cnt == CNT_ZERO);
  assign leave_save = (state == PSS_SAVE) && !cke_all_low;
  assign stop_expired = (state == PSS_SAVE) && cke_all_low && stop_s
    && (stop_cnt >= CNT_W'(CKEV_MIN_CYC));

  // sync eats two cycles, so two more are spent before the buffers go off
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      PSS_RESET: begin
        next_state = PSS_ACTIVE;
      end
      PSS_ACTIVE: begin
        if (ps_on && cke_all_low) begin
          next_state = PSS_ENTER;
          next_cnt = CNT_W'(INDIS_CYC - 1);
        end
      end
      PSS_ENTER: begin
        if (!cke_all_low) begin
          // host changed its mind before the buffers went off
          next_state = PSS_ACTIVE;
        end else if (cnt == CNT_ZERO) begin
          next_state = PSS_SAVE;
        end else begin
          next_cnt = cnt - CNT_ONE;
        end
      end
      PSS_SAVE: begin
        if (!cke_all_low) begin
          next_state = PSS_EXIT;
          next_cnt = CNT_W'(FIXOUT_CYC - 1);
        end
      end
      PSS_EXIT: begin
        // short settle before a new entry is taken
        if (cnt == CNT_ZERO) begin
          next_state = PSS_ACTIVE;
        end else begin
          next_cnt = cnt - CNT_ONE;
        end
      end
      default: begin
        next_state = PSS_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= PSS_RESET;
      cnt <= CNT_ZERO;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // clock-stop counter, cleared whenever the clock runs again; saturates
  always_comb begin
    next_stop_cnt = stop_cnt;
    if (state != PSS_SAVE || !stop_s) begin
      next_stop_cnt = CNT_ZERO;
    end else if (!stop_expired) begin
      next_stop_cnt = stop_cnt + CNT_ONE;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stop_cnt <= CNT_ZERO;
    end else begin
      stop_cnt <= next_stop_cnt;
    end
  end

  // wake beats a pending clock-stop disable, so the host never finds cke deaf
  always_comb begin
    next_psa = (next_state == PSS_SAVE);
    next_inbuf = input_buffers_enable;
    next_ckebuf = cke_buffers_enable;
    next_static = static_outputs_valid;
    if (boot) begin
      next_inbuf = 1'b1;
      next_ckebuf = 1'b1;
      next_static = 1'b1;
    end else if (enter_save) begin
      next_inbuf = 1'b0; // off 4 cycles after the pins drop
      next_static = 1'b0;
    end else if (leave_save) begin
      next_inbuf = 1'b1;
      next_ckebuf = 1'b1;
      next_static = 1'b1; // back 3 cycles after either pin rises
    end else if (stop_expired) begin
      next_ckebuf = 1'b0; // held at least 2 cycles past clock stop
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      input_buffers_enable <= 1'b0;
      cke_buffers_enable <= 1'b0;
      static_outputs_valid <= 1'b0;
      power_save_active <= 1'b0;
    end else begin
      input_buffers_enable <= next_inbuf;
      cke_buffers_enable <= next_ckebuf;
      static_outputs_valid <= next_static;
      power_save_active <= next_psa;
    end
  end

  // each registered enable follows its own pin one cycle after sync
  for (genvar i = 0; i < 2; i++) begin : g_qcke
    always_comb begin
      next_qcke[i] = cke_s[i];
    end
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        registered_clock_enable_outputs[i] <= 1'b0;
      end else begin
        registered_clock_enable_outputs[i] <= next_qcke[i];
      end
    end
  end

  // hi-z 1.5 cycles after the registered enables drop:
  // one rising stage, then one falling stage
  always_comb begin
    next_half_oe = !(ps_on && registered_clock_enable_outputs == 2'h0);
    next_oe_neg = half_oe;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      half_oe <= 1'b0;
    end else begin
      half_oe <= next_half_oe;
    end
  end

  always_ff @(negedge core_clk or negedge rstn) begin
    if (!rstn) begin
      oe_neg <= 1'b0;
    end else begin
      oe_neg <= next_oe_neg;
    end
  end

  // re-enable takes the same path; outputs stay parked while the enables are low and the upper control bit is set
  assign redriven_oe = oe_neg;
endmodule : pss_seq

// ===== verification/pss_seq_assertions.sv
`timescale 1ns/1ps
module pss_seq_assertions (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [1:0] clock_enable_inputs,
  input wire logic control_field_upper_bit,
  input wire logic clock_stopped,
  input wire logic input_buffers_enable,
  input wire logic cke_buffers_enable,
  input wire logic [1:0] registered_clock_enable_outputs,
  input wire logic redriven_oe,
  input wire logic static_outputs_valid,
  input wire logic power_save_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  buf_off_a: assert property (
    (clock_enable_inputs == 2'h0 && control_field_upper_bit)[*5] |-> !input_buffers_enable)
    else $error("input buffers still on");
  oe_hiz_a: assert property (
    $rose(registered_clock_enable_outputs == 2'h0) && control_field_upper_bit
    |-> redriven_oe ##1 !redriven_oe) else $error("output hi-z off half cycle");
  oe_half_a: assert property (@(negedge core_clk)
    $rose(registered_clock_enable_outputs == 2'h0) && control_field_upper_bit
    |-> ##1 redriven_oe ##1 !redriven_oe) else $error("output hi-z not at half cycle");
  cke_buf_hold_a: assert property (
    $rose(clock_stopped) && clock_enable_inputs == 2'h0
    |-> cke_buffers_enable[*2] ##[1:8] !cke_buffers_enable) else $error("cke buffers timing");
  static_back_a: assert property (
    $rose(clock_enable_inputs != 2'h0) && power_save_active |-> ##[1:3] static_outputs_valid)
    else $error("static outputs late");
endmodule : pss_seq_assertions
bind pss_seq pss_seq_assertions chk (.core_clk, .rstn, .clock_enable_inputs,
  .control_field_upper_bit, .clock_stopped, .input_buffers_enable, .cke_buffers_enable,
  .registered_clock_enable_outputs, .redriven_oe, .static_outputs_valid, .power_save_active);

// ===== verification/pss_host.sv
`timescale 1ns/1ps
module pss_host (
  input wire logic core_clk,
  output logic [1:0] clock_enable_inputs,
  output logic control_field_upper_bit,
  output logic control_field_lower_bit,
  output logic clock_stopped
);
  initial begin
    clock_enable_inputs = 2'h0;
    {control_field_upper_bit, control_field_lower_bit} = 2'h0;
    clock_stopped = 1'b0;
  end
  task automatic set_mode(input logic [1:0] fld);
    repeat (8) @(posedge core_clk);
    {control_field_upper_bit, control_field_lower_bit} <= fld;
  endtask : set_mode
  task automatic sleep(input logic stop);
    @(posedge core_clk) clock_enable_inputs <= 2'h0;
    repeat (8) @(posedge core_clk);
    clock_stopped <= stop;
  endtask : sleep
  task automatic wake(input logic [1:0] cke);
    @(posedge core_clk) clock_enable_inputs <= cke;
    clock_stopped <= 1'b0;
  endtask : wake
endmodule : pss_host

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] cke, rq;
  logic up, lo, stp, ibe, cbe, oe, sov, psa;
  int bad_count = 0;
  int n_compared = 0;
  always #5 core_clk = ~core_clk;
  pss_host host (.core_clk, .clock_enable_inputs(cke), .control_field_upper_bit(up),
    .control_field_lower_bit(lo), .clock_stopped(stp));
  pss_seq dut (.core_clk, .rstn, .clock_enable_inputs(cke), .control_field_upper_bit(up),
    .control_field_lower_bit(lo), .clock_stopped(stp), .input_buffers_enable(ibe),
    .cke_buffers_enable(cbe), .registered_clock_enable_outputs(rq), .redriven_oe(oe),
    .static_outputs_valid(sov), .power_save_active(psa));
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic t_save(input logic [1:0] fld, input logic [1:0] wk);
    host.set_mode(fld);
    host.sleep(1'b0);
    #1 chk({ibe, oe, psa}, {~fld[1], ~fld[1], fld[1]});
    chk(rq, 2'h0);
    host.wake(wk);
    repeat (3) @(posedge core_clk);
    #1 chk({ibe, sov}, 2'h3);
    chk(rq, wk);
  endtask : t_save
  task automatic t_stop;
    host.set_mode(2'h2);
    host.sleep(1'b1);
    @(posedge core_clk) #1 chk(cbe, 1'b1);
    repeat (8) @(posedge core_clk);
    #1 chk(cbe, 1'b0);
    host.wake(2'h3);
    repeat (3) @(posedge core_clk);
    #1 chk({cbe, sov}, 2'h3);
  endtask : t_stop
  initial begin
    repeat (7) @(posedge core_clk);
    #1 chk({ibe, oe, sov, psa}, 4'h0);
    @(posedge core_clk) rstn <= 1'b1;
    @(posedge core_clk) #1 chk({ibe, cbe}, 2'h3);
    host.wake(2'h3);
    t_save(2'h2, 2'h1);
    t_save(2'h3, 2'h2);
    t_save(2'h0, 2'h3);
    t_stop();
    results();
  end
  initial begin
    #20000;
    bad_count++;
    results();
  end
endmodule : tb
